/* File: hdl/afp_ctrl.v */
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "afp_map.vh"
module afp_ctrl #(
	parameter OT_RETRY_CYC = `AFP_OT_RETRY_CYC,
	parameter OC_RETRY_CYC = `AFP_OC_RETRY_CYC,
	parameter EXT_FALL_CYC = `AFP_EXT_FALL_CYC,
	parameter N_OUT        = 4
) (
	input  wire             mclk,
	input  wire             nrst,
	input  wire             ce,
	// Wishbone classic slave.
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [7:0]       wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [31:0]      wb_dat_i,
	output reg  [31:0]      wb_dat_o,
	output reg              wb_ack_o,
	output wire             irq,
	// Strap and sample-rate family.
	input  wire [3:0]       gain_rate_strap,
	input  wire             rate_family_44k1,
	// Analog monitor pins.
	input  wire             overtemp_event,
	input  wire [N_OUT-1:0] overcurrent_event,
	input  wire             stage_supply_low_level,
	input  wire             stage_supply_high_level,
	input  wire             analog_supply_low,
	input  wire             mute_monitor_in,
	input  wire             mute_level1,
	input  wire             mute_level2,
	input  wire             clock_error_notice,
	input  wire             mclk_halted,
	input  wire             sample_tick,
	// Outputs to the power stage.
	output reg              fault_out_n,
	output reg              speaker_outputs_hiz,
	output reg              soft_mute,
	output reg              analog_mute,
	output reg              output_shutdown,
	output reg              use_internal_osc,
	output reg              dac_hard_mute,
	output reg              pwm_stop,
	output reg  [7:0]       ramp_atten,
	output reg              gain_26db,
	output reg  [3:0]       switch_multiple,
	output reg              sync_88k2,
	output reg              strap_reserved
);
	// Machine for the clock-error and stage-undervoltage recovery path.
	localparam CS_RUN   = 3'b001;
	localparam CS_RAMP  = 3'b010;
	localparam CS_MUTED = 3'b100;

	wire        ot_s;
	wire        puv_s;
	wire        pov_s;
	wire        auv_s;
	wire        mute_s;
	wire        lvl1_s;
	wire        lvl2_s;
	wire        clkerr_s;
	wire        halt_s;
	wire        oc_s;
	wire [N_OUT-1:0] oc_sync;
	wire        ot_act;
	wire        oc_act;

	reg  [7:0]  ctrl_q;
	reg  [7:0]  ramp_cfg_q;
	reg  [3:0]  strap_q;
	reg         strap_done_q;
	reg  [`AFP_IRQ_W-1:0] irq_stat_q;
	reg  [`AFP_IRQ_W-1:0] irq_en_q;
	reg         halt_lat_q;
	reg         cerr_lat_q;
	reg  [2:0]  cst_q;
	reg  [1:0]  ramp_div_q;
	reg  [31:0] fall_cnt_q;
	reg         ext_mode_q;
	reg         mute_prev_q;
	reg  [`AFP_IRQ_W-1:0] ev_prev_q;
	wire [`AFP_IRQ_W-1:0] ev_now;

	// Synchronise every analog comparator output into the clock domain.
	afp_sync3 #(.W(9)) u_sync (
		.mclk   (mclk),
		.nrst   (nrst),
		.ce     (ce),
		.din    ({overtemp_event, stage_supply_low_level, stage_supply_high_level,
			analog_supply_low, mute_monitor_in, mute_level1, mute_level2,
			clock_error_notice, mclk_halted}),
		.dout_q ({ot_s, puv_s, pov_s, auv_s, mute_s, lvl1_s, lvl2_s, clkerr_s, halt_s})
	);

	afp_sync3 #(.W(N_OUT)) u_sync_oc (
		.mclk   (mclk),
		.nrst   (nrst),
		.ce     (ce),
		.din    (overcurrent_event),
		.dout_q (oc_sync)
	);

	assign oc_s = |oc_sync;

	// Hold each thermal or current fault for its clear time, then retry.
	afp_retry #(.RETRY(OT_RETRY_CYC)) u_ot (
		.mclk     (mclk),
		.nrst     (nrst),
		.ce       (ce),
		.event_in (ot_s),
		.active_q (ot_act)
	);

	afp_retry #(.RETRY(OC_RETRY_CYC)) u_oc (
		.mclk     (mclk),
		.nrst     (nrst),
		.ce       (ce),
		.event_in (oc_s),
		.active_q (oc_act)
	);

	// Decode of the strap code into the switching multiple.
	function [3:0] strap_mult;
		input [1:0] code;
		begin
			case (code)
				2'b00:   strap_mult = 4'd4;
				2'b01:   strap_mult = 4'd5;
				2'b10:   strap_mult = 4'd6;
				default: strap_mult = 4'd8;
			endcase
		end
	endfunction

	// The strap is sampled once, on the first enabled edge after reset release;
	// it is never reloaded until the next reset.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_q      <= 4'h0;
			strap_done_q <= 1'b0;
		end else if (ce && !strap_done_q) begin
			strap_q      <= gain_rate_strap;
			strap_done_q <= 1'b1;
		end
	end

	// Registered strap outputs and sync rate selection.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gain_26db       <= `AFP_GAIN_20DB;
			switch_multiple <= 4'd4;
			strap_reserved  <= 1'b0;
			sync_88k2       <= `AFP_SYNC_96K;
		end else if (ce) begin
			gain_26db       <= strap_q[2];
			switch_multiple <= strap_mult(strap_q[1:0]);
			strap_reserved  <= strap_q[3];
			sync_88k2       <= rate_family_44k1 ? `AFP_SYNC_88K2 : `AFP_SYNC_96K;
		end
	end

	// External undervoltage mode: the pin must stay low 6 ms after a fall.
	// A short dip is filtered out, which costs a 6 ms delay on real faults.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fall_cnt_q  <= 32'h0;
			ext_mode_q  <= 1'b0;
			mute_prev_q <= 1'b0;
		end else if (ce) begin
			mute_prev_q <= mute_s;
			if (mute_s) begin
				fall_cnt_q <= 32'h0;
				ext_mode_q <= 1'b0;
			end else if (mute_prev_q) begin
				fall_cnt_q <= 32'h1;
			end else if (fall_cnt_q != 32'h0 && !ext_mode_q) begin
				if (fall_cnt_q >= EXT_FALL_CYC[31:0]) begin
					ext_mode_q <= 1'b1;
				end else begin
					fall_cnt_q <= fall_cnt_q + 32'h1;
				end
			end
		end
	end

	// Clock error or stage undervoltage path: ramp down, then hard mute and stop switching.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cst_q      <= CS_RUN;
			ramp_atten <= 8'h00;
			ramp_div_q <= 2'b00;
		end else if (ce) begin
			case (cst_q)
				CS_RUN: begin
					ramp_atten <= 8'h00;
					ramp_div_q <= 2'b00;
					if (clkerr_s || puv_s) begin
						cst_q <= CS_RAMP;
					end
				end
				CS_RAMP: begin
					if (sample_tick) begin
						ramp_div_q <= ramp_div_q + 2'b01;
						// Rate 0,1,2 means every 1,2,4 fs; 3 jumps straight to the end.
						if (ramp_cfg_q[`AFP_RAMP_RATE_HI:`AFP_RAMP_RATE_LO] == 2'b11 ||
							ramp_atten >= `AFP_RAMP_STEPS) begin
							cst_q <= CS_MUTED;
						end else if ((ramp_cfg_q[`AFP_RAMP_RATE_HI:`AFP_RAMP_RATE_LO] == 2'b00) ||
							(ramp_cfg_q[`AFP_RAMP_RATE_HI:`AFP_RAMP_RATE_LO] == 2'b01 &&
							ramp_div_q[0]) ||
							(ramp_div_q == 2'b11)) begin
							// Step 0,1,2,3 gives 4, 2, 1, 0.5 dB in half-dB units.
							ramp_atten <= ramp_atten +
								(8'h08 >> ramp_cfg_q[`AFP_RAMP_STEP_HI:`AFP_RAMP_STEP_LO]);
						end
					end
					if (!clkerr_s && !puv_s) begin
						cst_q <= CS_RUN;
					end
				end
				CS_MUTED: begin
					if (!clkerr_s && !puv_s) begin
						cst_q <= CS_RUN;
					end
				end
				default: cst_q <= CS_RUN;
			endcase
		end
	end

	// Registered drive of the power stage and the fault line.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fault_out_n         <= 1'b1;
			speaker_outputs_hiz <= 1'b1;
			soft_mute           <= 1'b0;
			analog_mute         <= 1'b0;
			output_shutdown     <= 1'b0;
			use_internal_osc    <= 1'b0;
			dac_hard_mute       <= 1'b0;
			pwm_stop            <= 1'b0;
		end else if (ce) begin
			fault_out_n         <= !(ot_act || oc_act);
			speaker_outputs_hiz <= ot_act || oc_act || puv_s || pov_s ||
				(auv_s && ctrl_q[`AFP_CTRL_ASUP_MON]);
			soft_mute           <= ext_mode_q && lvl1_s;
			analog_mute         <= ext_mode_q && lvl2_s;
			output_shutdown     <= ext_mode_q && lvl2_s;
			use_internal_osc    <= (cst_q != CS_RUN) && clkerr_s;
			dac_hard_mute       <= (cst_q == CS_MUTED);
			pwm_stop            <= (cst_q == CS_MUTED);
		end
	end

	// Interrupt sources, rising edge of each condition.
	assign ev_now = {clkerr_s, ext_mode_q, auv_s && ctrl_q[`AFP_CTRL_ASUP_MON],
		pov_s, puv_s, oc_act, ot_act};

	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_req  = bus_req && wb_we_i && wb_sel_i[0];
	wire rd_clk  = bus_req && !wb_we_i && (wb_adr_i == `AFP_REG_CLKSTAT);
	wire clr_hit = wr_req && (wb_adr_i == `AFP_REG_IRQ_CLR);

	// Registers, latched clock flags and sticky interrupt bits; a set in the
	// same cycle as a clear or read wins so no event is lost.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q     <= `AFP_CTRL_RESET;
			ramp_cfg_q <= `AFP_RAMP_RESET;
			irq_en_q   <= {`AFP_IRQ_W{1'b0}};
			irq_stat_q <= {`AFP_IRQ_W{1'b0}};
			ev_prev_q  <= {`AFP_IRQ_W{1'b0}};
			halt_lat_q <= 1'b0;
			cerr_lat_q <= 1'b0;
		end else if (ce) begin
			ev_prev_q  <= ev_now;
			irq_stat_q <= (irq_stat_q & ~(clr_hit ? wb_dat_i[`AFP_IRQ_W-1:0] :
				{`AFP_IRQ_W{1'b0}})) | (ev_now & ~ev_prev_q);
			halt_lat_q <= (halt_lat_q && !rd_clk) || halt_s;
			cerr_lat_q <= (cerr_lat_q && !rd_clk) || clkerr_s;
			if (wr_req && wb_adr_i == `AFP_REG_CTRL) begin
				ctrl_q <= wb_dat_i[7:0];
			end
			if (wr_req && wb_adr_i == `AFP_REG_RAMP) begin
				ramp_cfg_q <= wb_dat_i[7:0];
			end
			if (wr_req && wb_adr_i == `AFP_REG_IRQ_EN) begin
				irq_en_q <= wb_dat_i[`AFP_IRQ_W-1:0];
			end
		end
	end

	// Read mux and one-cycle ack; unmapped addresses read as zero.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce) begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					`AFP_REG_CTRL:     wb_dat_o <= {24'h0, ctrl_q};
					`AFP_REG_STRAP:    wb_dat_o <= {28'h0, strap_q};
					`AFP_REG_STATUS:   wb_dat_o <= {24'h0, 1'b0, ev_now};
					`AFP_REG_CLKSTAT:  wb_dat_o <= {24'h0, 3'b000, halt_lat_q | halt_s,
						1'b0, dac_hard_mute, clkerr_s, cerr_lat_q | clkerr_s};
					`AFP_REG_IRQ_STAT: wb_dat_o <= {25'h0, irq_stat_q};
					`AFP_REG_IRQ_EN:   wb_dat_o <= {25'h0, irq_en_q};
					`AFP_REG_RAMP:     wb_dat_o <= {24'h0, ramp_cfg_q};
					default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);
endmodule // afp_ctrl
`default_nettype wire

/* File: hdl/afp_map.vh */
`ifndef AFP_MAP_VH
`define AFP_MAP_VH
// Register byte offsets.
`define AFP_REG_CTRL      8'h00
`define AFP_REG_STRAP     8'h04
`define AFP_REG_STATUS    8'h08
`define AFP_REG_CLKSTAT   8'h0c
`define AFP_REG_IRQ_STAT  8'h10
`define AFP_REG_IRQ_EN    8'h14
`define AFP_REG_IRQ_CLR   8'h18
`define AFP_REG_RAMP      8'h1c
// Control fields.
`define AFP_CTRL_ASUP_MON 0
`define AFP_CTRL_RESET    8'h00
// Emergency ramp fields: rate in [7:6], step in [5:4].
`define AFP_RAMP_RATE_HI  7
`define AFP_RAMP_RATE_LO  6
`define AFP_RAMP_STEP_HI  5
`define AFP_RAMP_STEP_LO  4
`define AFP_RAMP_RESET    8'h00
// Clock status fields that latch until read.
`define AFP_CLK_HALT_BIT  4
`define AFP_CLK_ERR_BIT   0
// Interrupt bit positions.
`define AFP_IRQ_OT        0
`define AFP_IRQ_OC        1
`define AFP_IRQ_PUV       2
`define AFP_IRQ_POV       3
`define AFP_IRQ_AUV       4
`define AFP_IRQ_EXT       5
`define AFP_IRQ_CLK       6
`define AFP_IRQ_W         7
// Gain codes and sync rate selects.
`define AFP_GAIN_20DB     1'b0
`define AFP_GAIN_26DB     1'b1
`define AFP_SYNC_96K      1'b0
`define AFP_SYNC_88K2     1'b1
// Timing.
`define AFP_CLK_MHZ       100
`define AFP_EXT_FALL_MS   6
`define AFP_EXT_FALL_CYC  (`AFP_EXT_FALL_MS * `AFP_CLK_MHZ * 1000)
`define AFP_OT_RETRY_CYC  1000000
`define AFP_OC_RETRY_CYC  1000000
`define AFP_RAMP_STEPS    8'd30
`endif

/* File: hdl/afp_retry.v */
`timescale 1ns/10ps
`default_nettype none
// Non-latching fault holder: stays active while the event is present and for
// RETRY cycles after it goes away, then releases on its own.
module afp_retry #(
	parameter RETRY = 1000000
) (
	input  wire mclk,
	input  wire nrst,
	input  wire ce,
	input  wire event_in,
	output reg  active_q
);
	reg [31:0] cnt_q;

	// Restart the clear time on every new occurrence of the event.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q    <= 32'h0;
			active_q <= 1'b0;
		end else if (ce) begin
			if (event_in) begin
				active_q <= 1'b1;
				cnt_q    <= RETRY[31:0];
			end else if (cnt_q > 32'h1) begin
				cnt_q <= cnt_q - 32'h1;
			end else begin
				cnt_q    <= 32'h0;
				active_q <= 1'b0;
			end
		end
	end
endmodule // afp_retry
`default_nettype wire

/* File: hdl/afp_sync3.v */
`timescale 1ns/10ps
`default_nettype none
// Three-stage input synchroniser; output changes once stages two and three agree.
module afp_sync3 #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         nrst,
	input  wire         ce,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout_q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer i;

	// Stage one is read only by stage two, keeping metastability contained.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_q   <= {W{1'b0}};
			s2_q   <= {W{1'b0}};
			s3_q   <= {W{1'b0}};
			dout_q <= {W{1'b0}};
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					dout_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule // afp_sync3
`default_nettype wire

/* File: testbench/afp_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// Ties the fault line and the speaker high-Z output to the pin levels that cause them.
module afp_ctrl_asserts #(
	parameter N_OUT = 4
) (
	input wire logic             mclk,
	input wire logic             nrst,
	input wire logic             ce,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_ack_o,
	input wire logic             overtemp_event,
	input wire logic [N_OUT-1:0] overcurrent_event,
	input wire logic             stage_supply_low_level,
	input wire logic             stage_supply_high_level,
	input wire logic             fault_out_n,
	input wire logic             speaker_outputs_hiz,
	input wire logic             gain_26db,
	input wire logic [3:0]       switch_multiple,
	input wire logic             strap_reserved,
	input wire logic             dac_hard_mute,
	input wire logic             pwm_stop
);
	logic [5:0] quiet_q;
	logic [2:0] up_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Saturating counters, so a long calm spell never wraps back to zero.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			quiet_q <= 6'h00;
			up_q    <= 3'h0;
		end else begin
			quiet_q <= (overtemp_event || |overcurrent_event) ? 6'h00 :
				quiet_q + {5'h00, quiet_q != 6'h3f};
			up_q    <= up_q + {2'h0, up_q != 3'h7};
		end
	end
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_ack_answer: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ot_fault: assert property (overtemp_event [*8] |-> !fault_out_n && speaker_outputs_hiz)
		else $error("overtemp did not raise fault");
	a_oc_fault: assert property ((|overcurrent_event) [*8] |-> !fault_out_n && speaker_outputs_hiz)
		else $error("overcurrent did not raise fault");
	a_low_supply_hiz: assert property (stage_supply_low_level [*8] |-> speaker_outputs_hiz)
		else $error("low stage supply left outputs driven");
	a_high_supply_hiz: assert property (stage_supply_high_level [*8] |-> speaker_outputs_hiz)
		else $error("high stage supply left outputs driven");
	a_fault_free: assert property (quiet_q >= 6'h28 |-> fault_out_n)
		else $error("fault line held after retry time");
	a_strap_kept: assert property (up_q >= 3'h4 |-> $stable({gain_26db, switch_multiple, strap_reserved}))
		else $error("strap decode changed after startup");
	a_stop_muted: assert property (pwm_stop |-> dac_hard_mute)
		else $error("switching stopped without hard mute");
endmodule // afp_ctrl_asserts
bind afp_ctrl afp_ctrl_asserts #(.N_OUT(N_OUT)) u_afp_chk (.mclk, .nrst, .ce, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .overtemp_event, .overcurrent_event, .stage_supply_low_level,
	.stage_supply_high_level, .fault_out_n, .speaker_outputs_hiz, .gain_26db, .switch_multiple,
	.strap_reserved, .dac_hard_mute, .pwm_stop);
`default_nettype wire

/* File: testbench/afp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host that reads and writes the registers over classic single Wishbone cycles.
module afp_host_model (
	input wire logic        mclk,
	output logic            wb_cyc_i,
	output logic            wb_stb_i,
	output logic            wb_we_i,
	output logic [7:0]      wb_adr_i,
	output logic [3:0]      wb_sel_i,
	output logic [31:0]     wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	// Bus idles low from time zero.
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
	end
	// One transfer; a missing ack returns unknown data so the caller's compare fails.
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		integer n;
		begin
			@(posedge mclk);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i  <= we;
			wb_adr_i <= a;
			wb_dat_i <= d;
			wb_sel_i <= 4'hf;
			n = 0;
			@(posedge mclk);
			while (wb_ack_o !== 1'b1 && n < 16) begin
				@(posedge mclk);
				n = n + 1;
			end
			q = (n < 16) ? wb_dat_o : 32'hxxxxxxxx;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i  <= 1'b0;
			@(posedge mclk);
		end
	endtask
endmodule // afp_host_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        mclk = 1'b0, nrst = 1'b0, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0]  wb_adr_i, ramp_atten;
	logic [3:0]  wb_sel_i, switch_multiple, strap = 4'h0, oc = 4'h0;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        ot = 1'b0, puv = 1'b0, pov = 1'b0, auv = 1'b0, fam = 1'b0, mute_in = 1'b1;
	logic        lv1 = 1'b0, lv2 = 1'b0, clk_err = 1'b0, halted = 1'b0, tick = 1'b0;
	logic        flt_n, hiz, sm, am, sd, osc, hm, ps, g26, sy, rsv;
	logic [1:0]  tick_q = 2'h0;
	integer      fails = 0, cmp_count = 0, cyc_cnt = 0, c;
	wire  [31:0] pins = {20'h0, flt_n, hiz, sm, am, sd, osc, hm, ps, sy, irq, g26, rsv};
	localparam logic [31:0] P_FLT = 32'h800, P_HIZ = 32'h400, P_SM = 32'h200, P_AM = 32'h100,
		P_SD = 32'h080, P_OSC = 32'h040, P_HM = 32'h020, P_PS = 32'h010, P_SY = 32'h008,
		P_IRQ = 32'h004, P_G26 = 32'h002, P_RSV = 32'h001;
	always #5 mclk = ~mclk;
	afp_ctrl #(.OT_RETRY_CYC(20), .OC_RETRY_CYC(20), .EXT_FALL_CYC(50)) u_dut (.mclk, .nrst,
		.ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .irq, .gain_rate_strap(strap), .rate_family_44k1(fam), .overtemp_event(ot),
		.overcurrent_event(oc), .stage_supply_low_level(puv), .stage_supply_high_level(pov),
		.analog_supply_low(auv), .mute_monitor_in(mute_in), .mute_level1(lv1),
		.mute_level2(lv2), .clock_error_notice(clk_err), .mclk_halted(halted),
		.sample_tick(tick), .fault_out_n(flt_n), .speaker_outputs_hiz(hiz), .soft_mute(sm),
		.analog_mute(am), .output_shutdown(sd), .use_internal_osc(osc), .dac_hard_mute(hm),
		.pwm_stop(ps), .ramp_atten, .gain_26db(g26), .switch_multiple, .sync_88k2(sy),
		.strap_reserved(rsv));
	afp_host_model u_host (.mclk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	// Sample tick every fourth cycle; the cycle count cuts a hang short.
	always @(posedge mclk) begin
		tick_q <= tick_q + 2'h1;
		tick <= (tick_q == 2'h3);
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			fails = fails + 1;
			final_report;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task pin(input logic [31:0] m, input logic [31:0] e);
		chk(pins & m, e);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task step(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task rst_pulse;
		@(posedge mclk);
		nrst <= 1'b0;
		step(10);
		nrst <= 1'b1;
	endtask
	task ended(input string s);
		$display("test %s done", s);
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Each strap code needs a fresh reset, since the level is only taken at startup.
	initial begin
		for (c = 8; c >= 0; c = c - 1) begin
			strap <= c[3:0];
			rst_pulse;
			step(4);
			strap <= ~c[3:0];
			step(4);
			if (c < 8) chk({28'h0, switch_multiple}, (c[1:0] == 2'h3) ? 32'h8 : 32'h4 + c[1:0]);
			pin((c == 8) ? P_RSV : P_G26 | P_RSV, (c == 8) ? P_RSV : (c > 3 ? P_G26 : 32'h0));
		end
		ended("strap");
		fam <= 1'b1;
		step(8);
		pin(P_SY, P_SY);
		fam <= 1'b0;
		step(8);
		pin(P_SY, 32'h0);
		rd(8'h1c, 32'hffffffff, 32'h0);
		wr(8'h40, 32'hff);
		rd(8'h40, 32'hffffffff, 32'h0);
		auv <= 1'b1;
		step(8);
		rd(8'h08, 32'h10, 32'h0);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'hffffffff, 32'h1);
		rd(8'h08, 32'h10, 32'h10);
		wr(8'h00, 32'h0);
		auv <= 1'b0;
		ended("registers");
		rd(8'h14, 32'hffffffff, 32'h0);
		ot <= 1'b1;
		step(10);
		pin(P_FLT | P_HIZ | P_IRQ, P_HIZ);
		ot <= 1'b0;
		wr(8'h14, 32'h1);
		pin(P_IRQ, P_IRQ);
		rd(8'h10, 32'h1, 32'h1);
		step(40);
		pin(P_FLT | P_HIZ, P_FLT);
		wr(8'h18, 32'h1);
		pin(P_IRQ, 32'h0);
		rd(8'h10, 32'h1, 32'h0);
		oc <= 4'h8;
		step(10);
		pin(P_FLT | P_HIZ | P_IRQ, P_HIZ);
		oc <= 4'h0;
		step(40);
		pin(P_FLT | P_HIZ, P_FLT);
		ended("faults");
		puv <= 1'b1;
		step(10);
		pin(P_FLT | P_HIZ, P_FLT | P_HIZ);
		puv <= 1'b0;
		pov <= 1'b1;
		step(10);
		pin(P_FLT | P_HIZ, P_FLT | P_HIZ);
		pov <= 1'b0;
		step(10);
		pin(P_HIZ, 32'h0);
		mute_in <= 1'b0;
		lv1 <= 1'b1;
		step(20);
		pin(P_SM, 32'h0);
		step(60);
		pin(P_SM | P_AM | P_SD, P_SM);
		lv2 <= 1'b1;
		step(8);
		pin(P_AM | P_SD, P_AM | P_SD);
		rd(8'h08, 32'h20, 32'h20);
		mute_in <= 1'b1;
		lv1 <= 1'b0;
		lv2 <= 1'b0;
		ended("supplies");
		strap <= 4'h0;
		rst_pulse;
		wr(8'h1c, 32'h30);
		rd(8'h1c, 32'hff, 32'h30);
		clk_err <= 1'b1;
		step(40);
		pin(P_OSC | P_HM | P_PS, P_OSC);
		wr(8'h1c, 32'h0);
		step(40);
		pin(P_HM | P_PS, P_HM | P_PS);
		// At rate 0, hard mute only follows a ramp that has reached its end point.
		chk({31'h0, ramp_atten >= 8'd30}, 32'h1);
		rd(8'h0c, 32'h7, 32'h7);
		clk_err <= 1'b0;
		step(8);
		rd(8'h0c, 32'h2, 32'h0);
		chk({24'h0, ramp_atten}, 32'h0);
		rd(8'h0c, 32'h13, 32'h0);
		halted <= 1'b1;
		step(6);
		halted <= 1'b0;
		step(6);
		rd(8'h0c, 32'h10, 32'h10);
		rd(8'h0c, 32'h10, 32'h0);
		pin(P_OSC, 32'h0);
		ended("clock");
		final_report;
	end
endmodule // tb
`default_nettype wire
